// *** hw/svc_pkg.sv ***
// Shared constants for the six-channel volume control serial slave
package svc_pkg;

    // ----------------------------------------
    // Bus framing
    // ----------------------------------------
    localparam int unsigned BYTE_BITS   = 8;
    localparam logic [2:0]  LAST_BIT    = 3'h7;
    localparam logic [7:0]  CHIP_ADDR_OPEN   = 8'h88;  // Select pin open
    localparam logic [7:0]  CHIP_ADDR_SUPPLY = 8'h8A;  // Select pin tied to supply

    // ----------------------------------------
    // Subaddress fields and register offsets
    // ----------------------------------------
    localparam int unsigned SUB_INC_BIT  = 4;
    localparam int unsigned SUB_IDX_MSB  = 3;
    localparam int unsigned NUM_CH       = 6;
    localparam logic [3:0]  OUT1_ATTENUATION = 4'h0;
    localparam logic [3:0]  OUT2_ATTENUATION = 4'h1;
    localparam logic [3:0]  OUT3_ATTENUATION = 4'h2;
    localparam logic [3:0]  OUT4_ATTENUATION = 4'h3;
    localparam logic [3:0]  OUT5_ATTENUATION = 4'h4;
    localparam logic [3:0]  OUT6_ATTENUATION = 4'h5;
    localparam logic [3:0]  FIRST_UNUSED_SUB = 4'h6;

    // ----------------------------------------
    // Attenuation byte layout and decode
    // ----------------------------------------
    localparam logic [7:0]  ATT_RESET     = 8'hC0;     // Muted after reset
    localparam int unsigned FINE_MSB      = 2;
    localparam int unsigned COARSE_LSB    = 3;
    localparam int unsigned COARSE_MSB    = 5;
    localparam int unsigned RANGE_LSB     = 6;
    localparam int unsigned RANGE_MSB     = 7;
    localparam logic [1:0]  RANGE_FINE    = 2'h0;
    localparam logic [1:0]  RANGE_64      = 2'h1;
    localparam logic [1:0]  RANGE_72      = 2'h2;
    localparam logic [1:0]  RANGE_MUTE    = 2'h3;
    localparam logic [3:0]  COARSE_STEPS_64 = 4'h8;   // 8 steps of 8 dB
    localparam logic [3:0]  COARSE_STEPS_72 = 4'h9;   // 9 steps of 8 dB
    localparam int unsigned DB_W          = 7;

    // ----------------------------------------
    // Receiver states
    // ----------------------------------------
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_ADDR,
        RX_SUB,
        RX_DATA,
        RX_ACK,
        RX_SKIP
    } svc_state_e;

endpackage : svc_pkg

// *** hw/svc_reg_if.sv ***
// Write port and stored values between the serial front end and the register store
`timescale 1ns/100ps

interface svc_reg_if;
    logic                                    wr_en;
    logic [2:0]                              wr_idx;
    logic [svc_pkg::BYTE_BITS-1:0]           wr_data;
    logic [svc_pkg::NUM_CH-1:0][svc_pkg::BYTE_BITS-1:0] att;

    modport ctrl  (output wr_en, output wr_idx, output wr_data, input att);
    modport store (input wr_en, input wr_idx, input wr_data, output att);
endinterface : svc_reg_if

// *** hw/svc_att_regs.sv ***
// Six attenuation registers written from the serial front end
`timescale 1ns/100ps

module svc_att_regs (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    svc_reg_if.store  regs
);

    // ----------------------------------------
    // One register per output channel
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < svc_pkg::NUM_CH; ch++)
        begin : g_ch
            // Hold value until rewritten
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    regs.att[ch] <= svc_pkg::ATT_RESET;
                else if (clk_en && regs.wr_en && regs.wr_idx == 3'(ch))
                    regs.att[ch] <= regs.wr_data;
            end
        end
    endgenerate

endmodule : svc_att_regs

// *** hw/svc_i2c_slave.sv ***
// Two-wire write-only slave feeding six attenuation registers with decode
//
// What this block does
// - Bytes are eight bits, MSB first, plus ack
// - Pull data low on ninth clock when addressed
// - Start, address, subaddress, data bytes, stop
// - Answer only chip address chosen by strap
// - Subaddress bit four enables auto-increment
// - Without increment, all data hit one register
// - With increment, step subaddress; drop 6 to 15
// - Low four subaddress bits select outputs 1-6
// - Fine 1 dB steps plus 8 dB coarse steps
// - Top bits give -64, -72 dB or mute
// - Start and stop are data edges, clock high
// - Data stable while clock high
`timescale 1ns/100ps

module svc_i2c_slave (
    input  wire logic                                  clk_sys,
    input  wire logic                                  sys_rst,
    input  wire logic                                  clk_en,
    input  wire logic                                  scl_in,
    input  wire logic                                  sda_in,
    output logic                                       sda_out,
    output logic                                       sda_oe_n,
    input  wire logic                                  addr_sel,
    output logic [svc_pkg::NUM_CH*svc_pkg::DB_W-1:0]   att_db,
    output logic [svc_pkg::NUM_CH-1:0]                 mute
);

    svc_reg_if regs ();

    svc_pkg::svc_state_e        state;
    svc_pkg::svc_state_e        ret_state;
    logic                       scl_q;
    logic                       sda_q;
    logic [2:0]                 bit_cnt;
    logic [6:0]                 shift;
    logic [3:0]                 sub_ptr;
    logic                       auto_inc;
    logic                       ack_drive;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_det;
    logic                       stop_det;
    logic [7:0]                 rx_byte;
    logic [7:0]                 chip_addr;
    logic                       byte_done;

    // ----------------------------------------
    // Line sampling and bus conditions
    // ----------------------------------------
    // Previous line levels
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else if (clk_en)
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Edges and frame conditions
    assign scl_rise  = scl_in & ~scl_q;
    assign scl_fall  = ~scl_in & scl_q;
    assign start_det = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;
    assign rx_byte   = {shift, sda_in};
    assign byte_done = scl_rise && bit_cnt == svc_pkg::LAST_BIT;
    assign chip_addr = addr_sel ? svc_pkg::CHIP_ADDR_SUPPLY
                                : svc_pkg::CHIP_ADDR_OPEN;

    // ----------------------------------------
    // Bit receiver
    // ----------------------------------------
    // Shift data on rising clock, MSB first
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            shift   <= 7'h00;
            bit_cnt <= 3'h0;
        end
        else if (clk_en)
        begin
            if (start_det || state == svc_pkg::RX_ACK)
                bit_cnt <= 3'h0;
            else if (scl_rise && (state == svc_pkg::RX_ADDR || state == svc_pkg::RX_SUB
                                  || state == svc_pkg::RX_DATA))
            begin
                shift   <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Transaction sequencer
    // ----------------------------------------
    // Frame states: address, subaddress, data, ack
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state     <= svc_pkg::RX_IDLE;
            ret_state <= svc_pkg::RX_IDLE;
        end
        else if (clk_en)
        begin
            if (start_det)
                state <= svc_pkg::RX_ADDR;
            else if (stop_det)
                state <= svc_pkg::RX_IDLE;
            else
            begin
                case (state)
                    svc_pkg::RX_ADDR:
                        if (byte_done)
                        begin
                            if (rx_byte == chip_addr)
                            begin
                                state     <= svc_pkg::RX_ACK;
                                ret_state <= svc_pkg::RX_SUB;
                            end
                            else
                                state <= svc_pkg::RX_SKIP;
                        end
                    svc_pkg::RX_SUB,
                    svc_pkg::RX_DATA:
                        if (byte_done)
                        begin
                            state     <= svc_pkg::RX_ACK;
                            ret_state <= svc_pkg::RX_DATA;
                        end
                    svc_pkg::RX_ACK:
                        if (ack_drive && scl_fall)
                            state <= ret_state;
                    svc_pkg::RX_IDLE,
                    svc_pkg::RX_SKIP:
                        state <= state;
                    default:
                        state <= svc_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Acknowledge driver
    // ----------------------------------------
    // Pull low from fall after bit 8 to fall after pulse 9
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ack_drive <= 1'b0;
            sda_oe_n  <= 1'b1;
            sda_out   <= 1'b0;
        end
        else if (clk_en)
        begin
            sda_out <= 1'b0;
            if (start_det || stop_det || state != svc_pkg::RX_ACK)
            begin
                ack_drive <= 1'b0;
                sda_oe_n  <= 1'b1;
            end
            else if (scl_fall)
            begin
                ack_drive <= ~ack_drive;
                sda_oe_n  <= ack_drive;
            end
        end
    end

    // ----------------------------------------
    // Subaddress pointer and register writes
    // ----------------------------------------
    // Latch subaddress, write data, step pointer
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sub_ptr       <= 4'h0;
            auto_inc      <= 1'b0;
            regs.wr_en    <= 1'b0;
            regs.wr_idx   <= 3'h0;
            regs.wr_data  <= 8'h00;
        end
        else if (clk_en)
        begin
            regs.wr_en <= 1'b0;
            if (byte_done && !start_det && !stop_det)
            begin
                if (state == svc_pkg::RX_SUB)
                begin
                    auto_inc <= rx_byte[svc_pkg::SUB_INC_BIT];
                    sub_ptr  <= rx_byte[svc_pkg::SUB_IDX_MSB:0];
                end
                else if (state == svc_pkg::RX_DATA)
                begin
                    // Slots 6 to 15 are passed over without a write
                    regs.wr_en   <= sub_ptr < svc_pkg::FIRST_UNUSED_SUB;
                    regs.wr_idx  <= sub_ptr[2:0];
                    regs.wr_data <= rx_byte;
                    if (auto_inc)
                        sub_ptr <= sub_ptr + 4'h1;
                    else
                        sub_ptr <= sub_ptr;
                end
            end
        end
    end

    svc_att_regs u_att_regs (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .regs    (regs)
    );

    // ----------------------------------------
    // Attenuation decode per channel
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < svc_pkg::NUM_CH; ch++)
        begin : g_dec
            logic [7:0] val;
            logic [3:0] coarse;
            assign val = regs.att[ch];

            // Coarse steps from range field or 8 dB bits
            always_comb
            begin
                case (val[svc_pkg::RANGE_MSB:svc_pkg::RANGE_LSB])
                    svc_pkg::RANGE_FINE:
                        coarse = {1'b0, val[svc_pkg::COARSE_MSB:svc_pkg::COARSE_LSB]};
                    svc_pkg::RANGE_64:
                        coarse = svc_pkg::COARSE_STEPS_64;
                    svc_pkg::RANGE_72:
                        coarse = svc_pkg::COARSE_STEPS_72;
                    default:
                        coarse = 4'h0;
                endcase
            end

            // Total dB of attenuation and mute flag
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    att_db[ch*svc_pkg::DB_W +: svc_pkg::DB_W] <= 7'h00;
                    mute[ch]                                   <= 1'b1;
                end
                else if (clk_en)
                begin
                    att_db[ch*svc_pkg::DB_W +: svc_pkg::DB_W] <=
                        {coarse, 3'h0} + {4'h0, val[svc_pkg::FINE_MSB:0]};
                    mute[ch] <= val[svc_pkg::RANGE_MSB:svc_pkg::RANGE_LSB]
                                == svc_pkg::RANGE_MUTE;
                end
            end
        end
    endgenerate

endmodule : svc_i2c_slave

// *** verif/svc_i2c_slave_chk.sv ***
// Port checks for the six-channel volume serial slave
`timescale 1ns/100ps

module svc_i2c_slave_chk (
    input wire logic                                      clk_sys,
    input wire logic                                      sys_rst,
    input wire logic                                      clk_en,
    input wire logic                                      scl_in,
    input wire logic                                      sda_in,
    input wire logic                                      sda_out,
    input wire logic                                      sda_oe_n,
    input wire logic                                      addr_sel,
    input wire logic [svc_pkg::NUM_CH*svc_pkg::DB_W-1:0] att_db,
    input wire logic [svc_pkg::NUM_CH-1:0]               mute
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Acknowledge drive, edges and length
    out_low_a: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    ack_start_a: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("ack began with clock high");
    ack_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
        else $error("data drive moved with clock high");
    ack_end_a: assert property ($rose(sda_oe_n) |-> !scl_in)
        else $error("ack ended with clock high");
    ack_len_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*4] ##[1:16] sda_oe_n)
        else $error("ack slot length wrong");
    upd_quiet_a: assert property (!$past(sys_rst) && ($changed(att_db) || $changed(mute))
        |-> sda_oe_n)
        else $error("outputs moved during ack");

    // Decode range per channel
    for (genvar i = 0; i < svc_pkg::NUM_CH; i++)
    begin : g_ch
        mute_fine_a: assert property (mute[i] |-> att_db[i*7 +: 7] < 7'h08)
            else $error("muted channel shows coarse level");
        att_max_a: assert property (att_db[i*7 +: 7] <= 7'h4f)
            else $error("level beyond range");
    end
endmodule : svc_i2c_slave_chk

bind svc_i2c_slave svc_i2c_slave_chk u_svc_i2c_slave_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
    .att_db(att_db), .mute(mute)
);

// *** verif/svc_master.sv ***
// Bus master model framing bytes on the two-wire control bus
`timescale 1ns/100ps

module svc_master (
    input  wire logic clk_sys,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_rel
);
    // Idle bus, both lines released
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // Wait n clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // Data edge with clock high: falling opens, rising closes
    task automatic edge_cond(input logic is_start);
        sda_rel = is_start;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_rel = !is_start;
        tick(4);
        if (is_start)
        begin
            scl = 1'b0;
            tick(2);
        end
    endtask : edge_cond

    // Eight bits MSB first, data moved only with clock low, then ack slot
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_rel = b[i];
            tick(2);
            scl = 1'b1;
            tick(4);
            scl = 1'b0;
            tick(2);
        end
        sda_rel = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        ack = !sda;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask : put_byte

    // Byte framed as usual, ack pulse clocked but never looked at
    task automatic put_blind(input logic [7:0] b);
        logic ignored;
        put_byte(b, ignored);
    endtask : put_blind
endmodule : svc_master

// *** verif/svc_i2c_slave_test.sv ***
// Self-checking bench for the six-channel volume serial slave
`timescale 1ns/100ps

module svc_i2c_slave_test;
    logic                                      clk_sys;
    logic                                      sys_rst;
    logic                                      clk_en;
    logic                                      addr_sel;
    logic                                      scl;
    logic                                      sda_rel;
    logic                                      sda_oe_n;
    logic                                      sda_out;
    logic                                      sda;
    logic [svc_pkg::NUM_CH*svc_pkg::DB_W-1:0] att_db;
    logic [svc_pkg::NUM_CH-1:0]               mute;
    logic [7:0]                                exp_reg [6];
    logic [7:0]                                q [$];
    logic                                      ack;
    int                                        fails;
    int                                        checks;

    // Open-drain wire, pulled up unless a side pulls low
    assign sda = sda_rel & (sda_oe_n | sda_out);

    svc_i2c_slave u_svc_i2c_slave (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .att_db(att_db),
        .mute(mute)
    );
    svc_master u_svc_master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_rel(sda_rel));

    // Count a comparison, report a mismatch
    task automatic cmp(input logic [7:0] got, input logic [7:0] want, input string what);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, want);
        end
    endtask : cmp

    // Expected level in dB from a stored byte
    function automatic logic [7:0] exp_db(input logic [7:0] v);
        logic [7:0] f;
        f = {5'h0, v[2:0]};
        case (v[7:6])
            2'h0:    return {2'h0, v[5:3], 3'h0} + f;
            2'h1:    return 8'h40 + f;
            2'h2:    return 8'h48 + f;
            default: return f;
        endcase
    endfunction : exp_db

    // Compare every channel level and mute flag
    task automatic chk_all();
        repeat (8) @(posedge clk_sys);
        #1;
        for (int c = 0; c < svc_pkg::NUM_CH; c++)
        begin
            cmp({1'b0, att_db[c*7 +: 7]}, exp_db(exp_reg[c]), "level");
            cmp({7'h0, mute[c]}, {7'h0, exp_reg[c][7:6] == 2'h3}, "mute");
        end
    endtask : chk_all

    // One frame: address, then queued bytes while addressed, then close
    task automatic wr(input logic [7:0] a, input logic ok);
        u_svc_master.edge_cond(1'b1);
        u_svc_master.put_byte(a, ack);
        cmp({7'h0, ack}, {7'h0, ok}, "address ack");
        if (ok)
            foreach (q[i])
            begin
                u_svc_master.put_byte(q[i], ack);
                cmp({7'h0, ack}, 8'h01, "byte ack");
            end
        u_svc_master.edge_cond(1'b0);
    endtask : wr

    // Verdict and end of run
    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // System clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = !clk_sys;
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        close_out();
    end

    // Main sequence
    initial
    begin
        fails = 0;
        checks = 0;
        sys_rst = 1'b1;
        addr_sel = 1'b0;
        clk_en = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        exp_reg = '{default: 8'hc0};
        chk_all();
        // Fixed pointer: every byte lands in one register
        q = {8'h02, 8'h05, 8'h0b};
        wr(8'h88, 1'b1);
        exp_reg[2] = 8'h0b;
        chk_all();
        // Stepping pointer from 14, high bits set, wrapping twice
        q = {8'hfe, 8'h00, 8'h00, 8'h3f, 8'h7f, 8'hba, 8'hc5, 8'h00, 8'h2f};
        repeat (10) q.push_back(8'h00);
        q.push_back(8'h01);
        wr(8'h88, 1'b1);
        exp_reg = '{8'h01, 8'h7f, 8'hba, 8'hc5, 8'h00, 8'h2f};
        chk_all();
        // Address strap selects which chip address answers
        q = {8'h05, 8'h10};
        wr(8'h8a, 1'b0);
        addr_sel = 1'b1;
        wr(8'h88, 1'b0);
        wr(8'h8a, 1'b1);
        exp_reg[5] = 8'h10;
        chk_all();
        // Enable low: start, address byte and stop pass unseen, address not acked, nothing stored
        clk_en = 1'b0;
        wr(8'h8a, 1'b0);
        clk_en = 1'b1;
        chk_all();
        // Ack slots clocked and sampled but never checked, bytes still land
        u_svc_master.edge_cond(1'b1);
        u_svc_master.put_blind(8'h8a);
        u_svc_master.put_blind(8'h14);
        u_svc_master.put_blind(8'h4a);
        u_svc_master.put_blind(8'h9b);
        u_svc_master.edge_cond(1'b0);
        exp_reg[4] = 8'h4a;
        exp_reg[5] = 8'h9b;
        chk_all();
        close_out();
    end
endmodule : svc_i2c_slave_test
